//--- mtac_pkg.sv
package mtac_pkg;
    localparam int CLK_HZ = 40000000;
    // Measurement period and response time.
    localparam int MEAS_TIME_US = 10000;
    localparam int MEAS_CYCLES = (MEAS_TIME_US * (CLK_HZ / 1000000));
    // Longest exposure inside a measurement.
    localparam int EXPO_TIME_US = 1300;
    localparam int EXPO_CYCLES = (EXPO_TIME_US * (CLK_HZ / 1000000));
    // Cascade pulse high time and following low time.
    localparam int CAS_HIGH_US = 100;
    localparam int CAS_HIGH_CYCLES = (CAS_HIGH_US * (CLK_HZ / 1000000));
    localparam int CAS_LOW_US = 1000;
    localparam int CAS_LOW_CYCLES = (CAS_LOW_US * (CLK_HZ / 1000000));
    localparam int CNT_W = 20;
    localparam int CAS_W = 17;
    // Display codes.
    localparam logic [1:0] DISP_CONTINUOUS = 2'h0;
    localparam logic [1:0] DISP_TRIGGERED = 2'h1;
    localparam logic [1:0] DISP_WAIT_ACT = 2'h2;
    // Operating mode and gating reset values.
    localparam logic MODE_CONTINUOUS = 1'b0;
    localparam logic GATE_DISREGARD = 1'b0;
    typedef enum logic [2:0] {
        MEAS_IDLE = 3'b001,
        MEAS_EXPOSE = 3'b010,
        MEAS_PROCESS = 3'b100
    } mtac_meas_type;
    typedef enum logic [2:0] {
        CAS_IDLE = 3'b001,
        CAS_HIGH = 3'b010,
        CAS_LOW = 3'b100
    } mtac_cas_type;
endpackage : mtac_pkg

//--- mtac_trig_detect.sv
`timescale 1ns/10ps
module mtac_trig_detect
    import mtac_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Trigger sources.
    input wire logic hw_trigger,
    input wire logic [7:0] count_byte,
    input wire logic count_valid,
    // Detected events.
    output logic hw_edge,
    output logic bus_change
);
    logic hw_prev;
    logic next_hw_prev;
    logic [7:0] stored;
    logic [7:0] next_stored;

    always_comb begin
        next_hw_prev = hw_trigger;
        next_stored = stored;
        hw_edge = hw_trigger & ~hw_prev; // R4
        bus_change = 1'b0;
        if (count_valid) begin
            bus_change = (count_byte != stored); // R10
            next_stored = count_byte; // R21
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hw_prev <= 1'b0;
            stored <= 8'h00;
        end else if (ce) begin
            hw_prev <= next_hw_prev;
            stored <= next_stored;
        end
    end
endmodule : mtac_trig_detect

//--- mtac_cascade_pulse.sv
`timescale 1ns/10ps
module mtac_cascade_pulse
    import mtac_pkg::*;
#(
    // Divides every timing count; 1 keeps the real timing.
    parameter int TIME_DIV = 1
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Control.
    input wire logic enable,
    input wire logic expo_done,
    // Pulse out.
    output logic cas_out
);
    mtac_cas_type state;
    mtac_cas_type next_state;
    logic [CAS_W-1:0] cnt;
    logic [CAS_W-1:0] next_cnt;
    logic next_cas_out;
    localparam int CAS_HIGH_LEN = CAS_HIGH_CYCLES / TIME_DIV;
    localparam int CAS_LOW_LEN = CAS_LOW_CYCLES / TIME_DIV;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_cas_out = 1'b0;
        case (state)
            CAS_IDLE: begin
                if (enable && expo_done) begin
                    next_state = CAS_HIGH; // R15
                    next_cnt = CAS_W'(CAS_HIGH_LEN - 1);
                    next_cas_out = 1'b1;
                end
            end
            CAS_HIGH: begin
                next_cas_out = 1'b1;
                if (cnt == '0) begin
                    next_state = CAS_LOW; // R20
                    next_cnt = CAS_W'(CAS_LOW_LEN - 1);
                    next_cas_out = 1'b0;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            CAS_LOW: begin
                // A done arriving here is dropped; it cannot occur at legal rates.
                if (cnt == '0) begin
                    next_state = CAS_IDLE; // R20
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            default: begin
                next_state = CAS_IDLE;
                next_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= CAS_IDLE;
            cnt <= '0;
            cas_out <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            cnt <= next_cnt;
            cas_out <= next_cas_out;
        end
    end
endmodule : mtac_cascade_pulse

//--- mtac_top.sv
`timescale 1ns/10ps
// Operation
// (R1) Continuous mode measures at 100 Hz and streams each result out.
// (R2) Every measurement finishes within 10 ms.
// (R3) Hardware, fieldbus or network trigger can start one measurement.
// (R4) Hardware trigger acts on its rising edge.
// (R5) Controller holds trigger pulses high at least 100 us.
// (R6) Controller keeps trigger low at least 1 ms between pulses.
// (R7) Controller asserts activation at least 100 us before trigger edge.
// (R8) Controller spaces trigger edges at least 10 ms apart.
// (R9) Reset gives continuous mode; hardware trigger acts only in triggered mode. Code: mode follows TRIGGERED_MODE; reset only loads DISP_CONTINUOUS.
// (R10) A change of the fieldbus count byte starts a measurement.
// (R11) Triggers arriving during a measurement are ignored.
// (R12) Activation switches laser and result output on; deactivation off.
// (R13) Disregard gating ignores activation and keeps measuring enabled.
// (R14) Regard gating measures only while activated, else shows wait code.
// (R15) Cascade output marks own exposure end, feeding next trigger input.
// (R16) A cascade chain holds at most six sensors.
// (R17) Downstream cascade sensors run triggered.
// (R18) Cascade output enabled on all but the last sensor.
// (R19) One exposure lasts at most 1.3 ms.
// (R20) Cascade pulse high and low times suit downstream trigger limits.
// (R21) Fieldbus byte is compared with stored copy, then stored.
module mtac_top
    import mtac_pkg::*;
#(
    // Divides every timing count; 1 keeps the real timing.
    parameter int TIME_DIV = 1
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    // Configuration.
    input wire logic TRIGGERED_MODE,
    input wire logic ACT_GATE_REGARD,
    input wire logic CASCADE_ENABLE,
    // Activation sources.
    input wire logic ACTIVATION_INPUT,
    input wire logic BUS_ACTIVATION_FLAG,
    input wire logic NET_ACTIVATION,
    // Trigger sources.
    input wire logic HW_TRIGGER,
    input wire logic [7:0] BUS_TRIGGER_COUNT_BYTE,
    input wire logic BUS_TRIGGER_VALID,
    input wire logic NET_TRIGGER,
    // Outputs.
    output logic LASER_ON,
    output logic DATA_OUT_EN,
    output logic EXPOSING,
    output logic MEAS_BUSY,
    output logic RESULT_STROBE,
    output logic CASCADE_OUT,
    output logic [1:0] DISPLAY_CODE
);
    mtac_meas_type state;
    mtac_meas_type next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic hw_edge;
    logic bus_change;
    logic enabled;
    logic start;
    logic expo_done;
    logic next_laser_on;
    logic next_data_out_en;
    logic next_exposing;
    logic next_busy;
    logic next_strobe;
    logic [1:0] next_display;
    // Only short bench runs divide the counts; the sensor itself keeps TIME_DIV at 1.
    localparam int MEAS_LEN = MEAS_CYCLES / TIME_DIV;
    localparam int EXPO_LEN = EXPO_CYCLES / TIME_DIV;

    // ------------------------------------------------------------
    // Trigger detection and cascade output
    // ------------------------------------------------------------
    mtac_trig_detect u_trig (
        .clk(CLK),
        .rst(SYS_RST),
        .ce(CLK_EN),
        .hw_trigger(HW_TRIGGER),
        .count_byte(BUS_TRIGGER_COUNT_BYTE),
        .count_valid(BUS_TRIGGER_VALID),
        .hw_edge(hw_edge),
        .bus_change(bus_change)
    );

    mtac_cascade_pulse #(.TIME_DIV(TIME_DIV)) u_cas (
        .clk(CLK),
        .rst(SYS_RST),
        .ce(CLK_EN),
        .enable(CASCADE_ENABLE),
        .expo_done(expo_done),
        .cas_out(CASCADE_OUT)
    );

    // ------------------------------------------------------------
    // Activation and start selection
    // ------------------------------------------------------------
    always_comb begin
        enabled = 1'b1; // R13
        if (ACT_GATE_REGARD) begin
            enabled = ACTIVATION_INPUT | BUS_ACTIVATION_FLAG | NET_ACTIVATION; // R14
        end
        start = 1'b0;
        if (enabled) begin
            if (TRIGGERED_MODE) begin
                start = hw_edge | bus_change | NET_TRIGGER; // R3 R9
            end else begin
                start = 1'b1; // R1
            end
        end
    end

    assign expo_done = (state == MEAS_EXPOSE) && (cnt == CNT_W'(EXPO_LEN - 1));

    // ------------------------------------------------------------
    // Measurement sequencer
    // ------------------------------------------------------------
    // The counter runs from the start of exposure to the end of the
    // 10 ms slot; continuous mode restarts after one idle cycle.
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_strobe = 1'b0;
        case (state)
            MEAS_IDLE: begin
                next_cnt = '0;
                if (start) begin
                    next_state = MEAS_EXPOSE;
                end
            end
            MEAS_EXPOSE: begin
                next_cnt = cnt + 1'b1;
                if (expo_done) begin
                    next_state = MEAS_PROCESS; // R19
                end
            end
            MEAS_PROCESS: begin
                // Triggers seen here are dropped, not queued.
                next_cnt = cnt + 1'b1; // R11
                if (cnt == CNT_W'(MEAS_LEN - 1)) begin
                    next_state = MEAS_IDLE; // R2
                    next_strobe = enabled; // R1 R12
                    next_cnt = '0;
                end
            end
            default: begin
                next_state = MEAS_IDLE;
                next_cnt = '0;
            end
        endcase
        next_exposing = (next_state == MEAS_EXPOSE);
        next_busy = (next_state != MEAS_IDLE);
        next_laser_on = enabled; // R12
        next_data_out_en = enabled; // R12
        if (!enabled) begin
            next_display = DISP_WAIT_ACT; // R14
        end else if (TRIGGERED_MODE) begin
            next_display = DISP_TRIGGERED; // R9
        end else begin
            next_display = DISP_CONTINUOUS; // R9
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state <= MEAS_IDLE;
            cnt <= '0;
            LASER_ON <= 1'b0;
            DATA_OUT_EN <= 1'b0;
            EXPOSING <= 1'b0;
            MEAS_BUSY <= 1'b0;
            RESULT_STROBE <= 1'b0;
            DISPLAY_CODE <= DISP_CONTINUOUS;
        end else if (CLK_EN) begin
            state <= next_state;
            cnt <= next_cnt;
            LASER_ON <= next_laser_on;
            DATA_OUT_EN <= next_data_out_en;
            EXPOSING <= next_exposing;
            MEAS_BUSY <= next_busy;
            RESULT_STROBE <= next_strobe;
            DISPLAY_CODE <= next_display;
        end
    end
endmodule : mtac_top

//--- mtac_assertions.sv
`timescale 1ns/10ps
// ----
// Port checks
// ----
module mtac_checker
    import mtac_pkg::*;
#(
    parameter int TIME_DIV = 1
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    // Configuration and sources.
    input wire logic TRIGGERED_MODE,
    input wire logic ACT_GATE_REGARD,
    input wire logic CASCADE_ENABLE,
    input wire logic ACTIVATION_INPUT,
    input wire logic BUS_ACTIVATION_FLAG,
    input wire logic NET_ACTIVATION,
    input wire logic HW_TRIGGER,
    // Outputs.
    input wire logic LASER_ON,
    input wire logic DATA_OUT_EN,
    input wire logic EXPOSING,
    input wire logic MEAS_BUSY,
    input wire logic RESULT_STROBE,
    input wire logic CASCADE_OUT,
    input wire logic [1:0] DISPLAY_CODE
);
    localparam int MEAS_LEN = MEAS_CYCLES / TIME_DIV;
    localparam int EXPO_LEN = EXPO_CYCLES / TIME_DIV;
    localparam int CAS_HIGH_LEN = CAS_HIGH_CYCLES / TIME_DIV;
    // Each counter holds the number of high samples, so at the fall it equals the length.
    logic [19:0] e_cnt, b_cnt, c_cnt;
    logic [19:0] next_e_cnt, next_b_cnt, next_c_cnt;
    wire logic act = ACTIVATION_INPUT | BUS_ACTIVATION_FLAG | NET_ACTIVATION;
    wire logic run = CLK_EN & (~ACT_GATE_REGARD | act);
    // Frozen edges are skipped, since the design holds all state there.
    always_comb begin
        next_e_cnt = EXPOSING ? e_cnt + 20'h1 : 20'h0;
        next_b_cnt = MEAS_BUSY ? b_cnt + 20'h1 : 20'h0;
        next_c_cnt = CASCADE_OUT ? c_cnt + 20'h1 : 20'h0;
    end
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            {e_cnt, b_cnt, c_cnt} <= 60'h0;
        end else if (CLK_EN) begin
            {e_cnt, b_cnt, c_cnt} <= {next_e_cnt, next_b_cnt, next_c_cnt};
        end
    end
    default clocking dc @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    expo_len_a: assert property ($fell(EXPOSING) |-> e_cnt == EXPO_LEN)
        else $error("exposure length wrong");
    busy_len_a: assert property ($fell(MEAS_BUSY) |-> b_cnt == MEAS_LEN)
        else $error("measurement length wrong");
    strobe_end_a: assert property (RESULT_STROBE |-> $fell(MEAS_BUSY))
        else $error("strobe outside measurement end");
    cas_after_a: assert property ($rose(CASCADE_OUT) |-> $fell(EXPOSING))
        else $error("cascade not at exposure end");
    cas_len_a: assert property ($fell(CASCADE_OUT) |-> c_cnt == CAS_HIGH_LEN)
        else $error("cascade high time wrong");
    cas_gate_a: assert property ($rose(CASCADE_OUT) |-> $past(CASCADE_ENABLE))
        else $error("cascade pulse while disabled");
    gate_off_a: assert property (CLK_EN && !ACT_GATE_REGARD |=> LASER_ON && DATA_OUT_EN)
        else $error("disregard gating not enabled");
    gate_wait_a: assert property (CLK_EN && ACT_GATE_REGARD && !act |=>
        !LASER_ON && !DATA_OUT_EN && DISPLAY_CODE == DISP_WAIT_ACT) else $error("no wait state");
    disp_mode_a: assert property (run |=>
        DISPLAY_CODE == ($past(TRIGGERED_MODE) ? DISP_TRIGGERED : DISP_CONTINUOUS))
        else $error("display code wrong");
    hw_start_a: assert property (run && TRIGGERED_MODE && HW_TRIGGER &&
        !$past(HW_TRIGGER) && !MEAS_BUSY |=> EXPOSING) else $error("edge did not start");
    busy_ign_a: assert property (MEAS_BUSY |=> !$rose(EXPOSING))
        else $error("start taken while busy");
endmodule : mtac_checker

bind mtac_top mtac_checker #(.TIME_DIV(TIME_DIV)) u_chk (
    .CLK, .SYS_RST, .CLK_EN, .TRIGGERED_MODE, .ACT_GATE_REGARD, .CASCADE_ENABLE,
    .ACTIVATION_INPUT,
    .BUS_ACTIVATION_FLAG, .NET_ACTIVATION, .HW_TRIGGER, .LASER_ON, .DATA_OUT_EN,
    .EXPOSING, .MEAS_BUSY, .RESULT_STROBE, .CASCADE_OUT, .DISPLAY_CODE
);

//--- mtac_plc_model.sv
`timescale 1ns/10ps
// ----
// Controller model
// ----
module mtac_plc_model
    import mtac_pkg::*;
#(
    // Same divider as the sensor, so pulse widths keep their ratio to a measurement.
    parameter int TIME_DIV = 1
) (
    // Clock.
    input wire logic clk,
    // Lines towards the sensor.
    output logic hw_trig,
    output logic act_in,
    output logic bus_act,
    output logic net_act,
    output logic net_trig,
    output logic valid,
    output logic [7:0] cnt_byte
);
    localparam int T100US = (100 * (CLK_HZ / 1000000)) / TIME_DIV;
    localparam int T1MS = (1000 * (CLK_HZ / 1000000)) / TIME_DIV;
    initial begin
        {hw_trig, act_in, bus_act, net_act, net_trig, valid} = 6'h0;
        cnt_byte = 8'h5a;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic set_act(input logic [2:0] a);
        {act_in, bus_act, net_act} = a;
        step(T100US);
    endtask : set_act
    task automatic hw_pulse();
        hw_trig = 1'h1;
        step(T100US);
        hw_trig = 1'h0;
        step(T1MS);
    endtask : hw_pulse
    // The byte is only qualified by valid, so it is scrambled between sends.
    task automatic bus_send(input logic [7:0] b);
        cnt_byte = b;
        valid = 1'h1;
        step(1);
        cnt_byte = ~b;
        valid = 1'h0;
    endtask : bus_send
    task automatic net_pulse();
        net_trig = 1'h1;
        step(1);
        net_trig = 1'h0;
    endtask : net_pulse
endmodule : mtac_plc_model

//--- tb.sv
`timescale 1ns/10ps
// ----
// Bench
// ----
module tb;
    import mtac_pkg::*;
    // All counts run forty times faster than real time to keep the run short.
    localparam int TDIV = 40;
    localparam int MEAS_LEN = MEAS_CYCLES / TDIV;
    localparam int EXPO_LEN = EXPO_CYCLES / TDIV;
    localparam int CAS_HIGH_LEN = CAS_HIGH_CYCLES / TDIV;
    logic CLK = 1'h0, SYS_RST = 1'h1, CLK_EN = 1'h1, CASCADE_ENABLE = 1'h1;
    logic TRIGGERED_MODE = 1'h0, ACT_GATE_REGARD = 1'h0;
    wire logic HW_TRIGGER, ACTIVATION_INPUT, BUS_ACTIVATION_FLAG, NET_ACTIVATION;
    wire logic NET_TRIGGER, BUS_TRIGGER_VALID;
    wire logic [7:0] BUS_TRIGGER_COUNT_BYTE;
    wire logic LASER_ON, DATA_OUT_EN, EXPOSING, MEAS_BUSY, RESULT_STROBE, CASCADE_OUT;
    wire logic [1:0] DISPLAY_CODE;
    int miscompares = 0, cmp_count = 0, cycles = 0;
    mtac_top #(.TIME_DIV(TDIV)) dut (.CLK, .SYS_RST, .CLK_EN, .TRIGGERED_MODE,
        .ACT_GATE_REGARD, .CASCADE_ENABLE, .ACTIVATION_INPUT, .BUS_ACTIVATION_FLAG,
        .NET_ACTIVATION, .HW_TRIGGER, .BUS_TRIGGER_COUNT_BYTE, .BUS_TRIGGER_VALID,
        .NET_TRIGGER, .LASER_ON, .DATA_OUT_EN, .EXPOSING, .MEAS_BUSY, .RESULT_STROBE,
        .CASCADE_OUT, .DISPLAY_CODE);
    mtac_plc_model #(.TIME_DIV(TDIV)) plc (.clk(CLK), .hw_trig(HW_TRIGGER),
        .act_in(ACTIVATION_INPUT), .bus_act(BUS_ACTIVATION_FLAG),
        .net_act(NET_ACTIVATION), .net_trig(NET_TRIGGER),
        .valid(BUS_TRIGGER_VALID), .cnt_byte(BUS_TRIGGER_COUNT_BYTE));
    always #12.5 CLK = ~CLK;
    // Five measurement slots; the scenarios need a little more than three.
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 5 * MEAS_LEN) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_end(output int n);
        n = 0;
        while (RESULT_STROBE !== 1'h1 && n < MEAS_LEN + 10) begin
            tick(1);
            n++;
        end
    endtask : wait_end
    task automatic run_free();
        int n;
        tick(1);
        chk({EXPOSING, LASER_ON, DISPLAY_CODE}, {2'h3, DISP_CONTINUOUS});
        tick(EXPO_LEN);
        chk({EXPOSING, CASCADE_OUT}, 2'h1);
        tick(CAS_HIGH_LEN - 1);
        chk(CASCADE_OUT, 1'h1);
        tick(1);
        chk(CASCADE_OUT, 1'h0);
        wait_end(n);
        chk(n + EXPO_LEN + CAS_HIGH_LEN, MEAS_LEN);
        tick(1);
        chk({EXPOSING, MEAS_BUSY}, 2'h3);
    endtask : run_free
    task automatic run_trig();
        int n;
        SYS_RST = 1'h1;
        TRIGGERED_MODE = 1'h1;
        ACT_GATE_REGARD = 1'h1;
        tick(4);
        SYS_RST = 1'h0;
        tick(2);
        chk({LASER_ON, DISPLAY_CODE}, {1'h0, DISP_WAIT_ACT});
        plc.net_pulse();
        chk(MEAS_BUSY, 1'h0);
        for (int i = 0; i < 3; i++) begin
            plc.set_act(3'h1 << i);
            chk({LASER_ON, DATA_OUT_EN, DISPLAY_CODE}, {2'h3, DISP_TRIGGERED});
        end
        plc.hw_pulse();
        chk(EXPOSING, 1'h1);
        plc.net_pulse();
        plc.bus_send(8'h01);
        wait_end(n);
        chk(n, MEAS_LEN + 1 - plc.T100US - plc.T1MS - 2);
        tick(3);
        chk(MEAS_BUSY, 1'h0);
    endtask : run_trig
    task automatic run_bus();
        int n;
        ACT_GATE_REGARD = 1'h0;
        CASCADE_ENABLE = 1'h0;
        plc.set_act(3'h0);
        chk(LASER_ON, 1'h1);
        plc.bus_send(8'h01);
        tick(2);
        chk(MEAS_BUSY, 1'h0);
        plc.bus_send(8'h02);
        chk(EXPOSING, 1'h1);
        wait_end(n);
        chk(n, MEAS_LEN);
        tick(1);
        plc.net_pulse();
        chk(EXPOSING, 1'h1);
    endtask : run_bus
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    initial begin
        tick(4);
        SYS_RST = 1'h0;
        run_free();
        run_trig();
        run_bus();
        end_sim();
    end
endmodule : tb
